//--- src/accel_mode_core.v
/*
 * Mode control, trim loading, output formatting and auto-wake/sleep for a
 * three-axis accelerometer. Raw samples arrive from the converter with a
 * strobe clock from outside this domain; detector events and all control
 * bits come from logic on clk_sys. The host bus sits outside this block.
 */
`include "accel_mode_defs.vh"

module accel_mode_core
#(
    parameter BASE_PERIOD = `BASE_PERIOD_CYC  // Cycles per fastest sample
)
(
    input  wire        clk_sys,
    input  wire        rst_b,
    input  wire        active,          // Active control bit
    input  wire        fast_read,       // Eight-bit output select
    input  wire [1:0]  full_scale,      // Range code
    input  wire        low_noise,       // Low-noise select
    input  wire [1:0]  oversampling_ratio, // Averaging of 1,2,4,8
    input  wire        hpf_out_en,      // High-pass filtered output
    input  wire [2:0]  wake_rate,       // output_sample_rate while awake
    input  wire [2:0]  sleep_rate,      // output_sample_rate asleep
    input  wire        auto_sleep_en,
    input  wire [7:0]  sleep_timeout,   // Sample ticks before sleep
    input  wire [4:0]  event_fire,      // Detector event pulses
    input  wire [4:0]  wake_src_en,     // Detectors that keep it awake
    input  wire [5:0]  int_enable,      // Per source interrupt enable
    input  wire [5:0]  int_route,       // 1 sends source to pin one
    input  wire [5:0]  int_clear,       // Clear pulses for flags
    input  wire        adc_clk,         // Converter strobe clock
    input  wire [47:0] adc_data,        // Three raw 16-bit words
    input  wire [23:0] user_offset,     // Three signed host offsets
    output reg         nvm_rd,          // Trim read request
    output reg  [2:0]  nvm_addr,        // Trim word address
    input  wire [7:0]  nvm_data,        // Trim word
    input  wire        nvm_ack,         // Trim word valid
    output reg         boot_done,
    output reg         analog_en,       // Analog subsystem enable
    output wire        sample_tick,     // Sample clock enable pulse
    output wire [1:0]  thresh_range,    // Range that scales thresholds
    output reg         sleeping,
    output reg  [23:0] out_msb,         // High bytes x,y,z
    output reg  [23:0] out_lsb,         // Low bytes x,y,z
    output reg  [5:0]  int_flags,
    output reg         int1,
    output reg         int2
);

    // Boot loader states
    localparam BOOT_REQ  = 2'h0;
    localparam BOOT_WAIT = 2'h1;
    localparam BOOT_DONE = 2'h2;
    // Sleep machine states
    localparam ST_WAKE   = 1'b0;
    localparam ST_SLEEP  = 1'b1;

    reg  [1:0]  boot_q;                 // Loader state
    reg  [47:0] trim_q;                 // Gains then offsets
    reg         active_q;               // Active bit one cycle late
    wire        go_active;              // Standby to active edge
    reg  [2:0]  adc_clk_s;              // Strobe synchroniser and edge
    reg  [47:0] adc_d1_q;               // Data synchroniser stage one
    reg  [47:0] adc_d2_q;               // Data synchroniser stage two
    wire        adc_stb;                // Raw sample taken
    reg  [2:0]  osr_cnt_q;              // Raw samples summed so far
    wire [2:0]  osr_last;               // Final index of a group
    wire        osr_done;               // Group completes this strobe
    reg         avg_vld_q;              // Averaged sample ready
    reg  [`RATE_CNT_W-1:0] rate_cnt_q;  // Sample divider
    wire [`RATE_CNT_W-1:0] rate_top;    // Divider limit
    reg         state_q;                // Wake or sleep
    reg  [`ASLP_W-1:0] aslp_cnt_q;      // Idle sample ticks
    wire        wake_evt;               // Any wake-source event
    reg         chg_q;                  // Sleep/wake change pulse
    wire [5:0]  src;                    // Interrupt sources
    wire [1:0]  eff_range;              // Range after low-noise
    wire [31:0] rate_wide;              // Divider limit before trimming

    // Low-noise pins the range at 4 g for output and detectors
    // Code 3 is treated as 8 g, so detectors never see an odd range
    assign eff_range = low_noise ? `RANGE_4G :
                       full_scale[1] ? `RANGE_8G : full_scale;
    assign thresh_range = eff_range;

    // Startup loader pulls six trim words before sampling may start
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            boot_q    <= BOOT_REQ;
            nvm_rd    <= 1'b0;
            nvm_addr  <= `NVM_ADDR_RST;
            boot_done <= 1'b0;
            trim_q    <= {{3{`TRIM_OFF_RST}}, {3{`TRIM_GAIN_RST}}};
        end
        else
        begin
            case (boot_q)
                BOOT_REQ:
                begin
                    nvm_rd <= 1'b1;
                    boot_q <= BOOT_WAIT;
                end
                BOOT_WAIT:
                begin
                    nvm_rd <= 1'b0;
                    if (nvm_ack)
                    begin
                        // Word n lands in byte lane n of the trim store
                        trim_q[nvm_addr*8 +: 8] <= nvm_data;
                        if (nvm_addr == `TRIM_WORDS - 3'h1)
                        begin
                            boot_q    <= BOOT_DONE;
                            boot_done <= 1'b1;
                        end
                        else
                        begin
                            nvm_addr <= nvm_addr + 3'h1;
                            boot_q   <= BOOT_REQ;
                        end
                    end
                end
                default:
                begin
                    nvm_rd <= 1'b0;
                end
            endcase
        end
    end

    // Pin inputs pass two flops; the edge uses the second strobe stage and a third
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            adc_clk_s <= 3'h0;
            adc_d1_q  <= 48'h000000000000;
            adc_d2_q  <= 48'h000000000000;
            active_q  <= 1'b0;
            analog_en <= 1'b0;
        end
        else
        begin
            adc_clk_s <= {adc_clk_s[1:0], adc_clk};
            adc_d1_q  <= adc_data;
            adc_d2_q  <= adc_d1_q;
            active_q  <= active;
            analog_en <= active;
        end
    end

    // Raw words are trusted only in active mode after trim is loaded
    assign adc_stb  = adc_clk_s[1] & ~adc_clk_s[2] & active_q &
                      boot_done;
    assign go_active = active & ~active_q;
    assign osr_last = (3'h1 << oversampling_ratio) - 3'h1;
    assign osr_done = adc_stb & (osr_cnt_q == osr_last);

    // Oversampling group counter; its length affects output only
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            osr_cnt_q <= `OSR_ZERO;
            avg_vld_q <= 1'b0;
        end
        else
        begin
            avg_vld_q <= osr_done;
            if (go_active | osr_done)
                osr_cnt_q <= `OSR_ZERO;
            else if (adc_stb)
                osr_cnt_q <= osr_cnt_q + 3'h1;
        end
    end

    // Sample divider; held at zero in standby so no sampling clock runs
    // Parameter arithmetic is 32 bits wide; the divider keeps the low bits
    assign rate_wide = (BASE_PERIOD << (state_q ? sleep_rate : wake_rate))
                       - 1;
    assign rate_top = rate_wide[`RATE_CNT_W-1:0];
    // Live bit gates too, so no tick lands once standby is asked for
    assign sample_tick = active & active_q & boot_done &
                         (rate_cnt_q == rate_top);

    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            rate_cnt_q <= {`RATE_CNT_W{1'b0}};
        else if (!active_q | sample_tick | go_active)
            rate_cnt_q <= {`RATE_CNT_W{1'b0}};
        else
            rate_cnt_q <= rate_cnt_q + 1'b1;
    end

    // Per-axis trim, averaging, offset, filter and format
    genvar ax;
    generate
        for (ax = 0; ax < 3; ax = ax + 1)
        begin : g_axis
            reg  signed [`ACC_W-1:0]  acc_q;    // Oversampling sum
            reg  signed [`COMP_W-1:0] avg_q;    // Averaged sample
            reg  signed [`COMP_W-1:0] mean_q;   // High-pass running mean
            reg  signed [`OUT_W-1:0]  smp_q;    // Formatted sample
            wire signed [`RAW_W-1:0]  raw;
            wire signed [`PROD_W-1:0] prod;
            wire signed [`COMP_W-1:0] comp;
            wire signed [`ACC_W-1:0]  sum;
            wire signed [`COMP_W-1:0] hp;
            wire signed [`COMP_W-1:0] sel;
            wire signed [`COMP_W-1:0] scl;
            wire signed [`OUT_W-1:0]  sat;
            wire signed [`ACC_W-1:0]  avg_full; // Group sum over its length

            assign raw  = adc_d2_q[ax*16 +: 16];
            // Factory gain is unsigned with 1.0 at mid code
            assign prod = raw * $signed({1'b0, trim_q[ax*8 +: 8]});
            assign comp = prod[`PROD_W-1:`GAIN_SHIFT] +
                $signed({{10{trim_q[24+ax*8+7]}},
                         trim_q[24+ax*8 +: 8]});
            assign sum  = acc_q + {{3{comp[`COMP_W-1]}}, comp};
            assign avg_full = sum >>> oversampling_ratio;
            // Mean removed only from output, detectors see raw data
            assign hp   = avg_q - mean_q;
            assign sel  = (hpf_out_en ? hp : avg_q) +
                $signed({{10{user_offset[ax*8+7]}},
                         user_offset[ax*8 +: 8]});
            // Raw word is 2 g counts; wider ranges weigh counts more
            assign scl  = (eff_range == `RANGE_2G) ? sel :
                          (eff_range == `RANGE_4G) ? (sel >>> 1) :
                          (sel >>> 2);
            // Clamp keeps -FS to +FS minus one count
            assign sat  = (scl > `SAT_HI) ? `OUT_MAX :
                          (scl < `SAT_LO) ? `OUT_MIN :
                          scl[`OUT_W-1:0];

            // Accumulate a group then shift by its length
            always @(posedge clk_sys or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    acc_q  <= `ACC_ZERO;
                    avg_q  <= {`COMP_W{1'b0}};
                    mean_q <= {`COMP_W{1'b0}};
                    smp_q  <= {`OUT_W{1'b0}};
                end
                else if (go_active)
                begin
                    acc_q  <= `ACC_ZERO;
                    smp_q  <= {`OUT_W{1'b0}};
                end
                else
                begin
                    if (osr_done)
                    begin
                        acc_q <= `ACC_ZERO;
                        avg_q <= avg_full[`COMP_W-1:0];
                    end
                    else if (adc_stb)
                        acc_q <= sum;
                    if (avg_vld_q)
                    begin
                        mean_q <= mean_q + (hp >>> `HPF_SHIFT);
                        smp_q  <= sat;
                    end
                end
            end

            // Output bytes refresh on the sample clock; held in standby
            always @(posedge clk_sys or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    out_msb[ax*8 +: 8] <= 8'h00;
                    out_lsb[ax*8 +: 8] <= 8'h00;
                end
                else if (go_active)
                begin
                    out_msb[ax*8 +: 8] <= 8'h00;
                    out_lsb[ax*8 +: 8] <= 8'h00;
                end
                else if (sample_tick)
                begin
                    out_msb[ax*8 +: 8] <= smp_q[13:6];
                    // Fast read leaves the low byte empty
                    out_lsb[ax*8 +: 8] <= fast_read ? `FAST_LSB :
                        {smp_q[5:0], `LSB_PAD};
                end
            end
        end
    endgenerate

    // Any enabled wake source restarts the idle count
    assign wake_evt = |(event_fire & wake_src_en);

    // Auto sleep machine; state and timer held in standby, reset to awake on activation
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q    <= ST_WAKE;
            aslp_cnt_q <= `ASLP_ZERO;
            chg_q      <= 1'b0;
            sleeping   <= 1'b0;
        end
        else
        begin
            chg_q <= 1'b0;
            if (go_active | !auto_sleep_en)
            begin
                // Entering active always starts awake
                if (state_q == ST_SLEEP)
                    chg_q <= auto_sleep_en;
                state_q    <= ST_WAKE;
                aslp_cnt_q <= `ASLP_ZERO;
            end
            else if (active_q)
            begin
                case (state_q)
                    ST_WAKE:
                    begin
                        if (wake_evt)
                            aslp_cnt_q <= `ASLP_ZERO;
                        else if (sample_tick)
                        begin
                            if (aslp_cnt_q >= sleep_timeout)
                            begin
                                state_q    <= ST_SLEEP;
                                chg_q      <= 1'b1;
                                aslp_cnt_q <= `ASLP_ZERO;
                            end
                            else
                                aslp_cnt_q <= aslp_cnt_q + 8'h01;
                        end
                    end
                    default:
                    begin
                        if (wake_evt)
                        begin
                            state_q <= ST_WAKE;
                            chg_q   <= 1'b1;
                        end
                    end
                endcase
            end
            sleeping <= (state_q == ST_SLEEP);
        end
    end

    // Sources: detectors in the low bits, sleep/wake change on top
    assign src = {chg_q, event_fire} & int_enable;

    // Sticky flags; a new event wins over a clear in the same cycle
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            int_flags <= `SRC_ZERO;
            int1      <= 1'b0;
            int2      <= 1'b0;
        end
        else
        begin
            int_flags <= (int_flags & ~int_clear) | src;
            int1 <= |(int_flags & int_route);
            int2 <= |(int_flags & ~int_route);
        end
    end

endmodule // accel_mode_core

//--- src/accel_mode_defs.vh
/*
 * Constants for the accelerometer mode control and output formatting core.
 * Assumes a 40 MHz system clock and a 16-bit raw converter word per axis.
 */
`ifndef ACCEL_MODE_DEFS_VH
`define ACCEL_MODE_DEFS_VH

// Clock and sample timing
`define CLK_PERIOD_NS     25
`define BASE_RATE_HZ      800
`define BASE_PERIOD_CYC   ((1000000000 / `CLK_PERIOD_NS) / `BASE_RATE_HZ)
`define RATE_CNT_W        24

// Full-scale range codes
`define RANGE_2G          2'h0
`define RANGE_4G          2'h1
`define RANGE_8G          2'h2

// Data widths
`define RAW_W             16
`define OUT_W             14
`define PROD_W            25
`define COMP_W            18
`define ACC_W             21
`define ACC_ZERO          21'h000000
`define LSB_PAD           2'h0
`define FAST_LSB          8'h00

// Sample saturation limits for the 14-bit format
`define OUT_MAX           14'h1FFF
`define OUT_MIN           14'h2000
`define SAT_HI            18'sh01FFF
`define SAT_LO            -18'sh02000

// Trim storage
`define TRIM_WORDS        3'h6
`define TRIM_GAIN_RST     8'h80
`define TRIM_OFF_RST      8'h00
`define GAIN_SHIFT        7
`define NVM_ADDR_RST      3'h0

// High-pass filter corner, as a shift of the running mean
`define HPF_SHIFT         4

// Event sources: five detectors plus the sleep/wake change
`define NUM_EVT           5
`define NUM_SRC           6
`define SRC_ZERO          6'h00

// Sleep timeout and oversampling counters
`define ASLP_W            8
`define ASLP_ZERO         8'h00
`define OSR_ZERO          3'h0

`endif

//--- tb/accel_mode_and_data_format_test.sv
/*
 * Bench for the accel mode core: trim boot, ranges, formats,
 * oversampling, retention, event pins and auto sleep.
 * Assumes nvm_model and the bound checker are compiled first.
 */
module accel_mode_and_data_format_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys = 1'h0;
    logic        rst_b = 1'h0;
    logic        active = 1'h0;     // Start in standby
    logic        fast_read = 1'h0;
    logic [1:0]  full_scale = 2'h0;
    logic        low_noise = 1'h0;
    logic [1:0]  oversampling_ratio = 2'h0;
    logic        hpf_out_en = 1'h0; // No expected model for the filter
    logic [2:0]  wake_rate = 3'h0;
    logic [2:0]  sleep_rate = 3'h1;
    logic        auto_sleep_en = 1'h0;
    logic [7:0]  sleep_timeout = 8'h03;
    logic [4:0]  event_fire = 5'h00;
    logic [4:0]  wake_src_en = 5'h01;
    logic [5:0]  int_enable = 6'h3F;
    logic [5:0]  int_route = 6'h20;   // Sleep change to pin one
    logic [5:0]  int_clear = 6'h00;
    logic        adc_clk = 1'h0;      // Still between samples
    logic [47:0] adc_data = 48'h0;
    logic [23:0] user_offset = 24'h000005;
    logic        nvm_rd, nvm_ack, boot_done, analog_en, sample_tick;
    logic        sleeping, int1, int2;
    logic [2:0]  nvm_addr;
    logic [7:0]  nvm_data;
    logic [1:0]  thresh_range;
    logic [23:0] out_msb, out_lsb;
    logic [5:0]  int_flags;
    int err_total = 0, n_compared = 0, cycles = 0, ticks = 0, i;
    int r[3], q[3];
    int g[3] = '{128, 64, 128}; // Trim gains per axis
    int o[3] = '{7, -2, 0};     // Trim plus host offsets per axis
    int sh[5] = '{0, 1, 2, 2, 1}; // Range code equals scale shift

    accel_mode_core #(.BASE_PERIOD(20)) accel_mode_core_inst (.*);
    nvm_model #(.DLY(2)) nvm_model_inst (.clk_sys(clk_sys),
        .rst_b(rst_b), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr),
        .nvm_data(nvm_data), .nvm_ack(nvm_ack));

    always #12.5 clk_sys = ~clk_sys;

    // Cycle ceiling well above the twelve hundred or so the tests need
    always @(posedge clk_sys)
    begin
        cycles++;
        if (sample_tick === 1'h1)
            ticks++;
        if (cycles == 8000)
        begin
            err_total++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (err_total == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input string what, input logic [23:0] exp,
                         input logic [23:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Scale, then saturate to 14 bits; the floor shift matches >>>
    function automatic logic [13:0] scaled(input int raw, gn, off, s);
        int v;
        v = (((raw * gn) >>> 7) + off) >>> s;
        if (v > 8191)
            v = 8191;
        if (v < -8192)
            v = -8192;
        return v[13:0];
    endfunction

    // One strobe per sample, 200 ns period, data steady around the rise
    task automatic feed(input int n);
        repeat (n)
        begin
            adc_data = {r[2][15:0], r[1][15:0], r[0][15:0]};
            repeat (4) @(negedge clk_sys);
            adc_clk = 1'h1;
            repeat (4) @(negedge clk_sys);
            adc_clk = 1'h0;
        end
        repeat (50) @(negedge clk_sys);
    endtask

    task automatic check_axes(input int s, input bit fast);
        logic [13:0] v;
        logic [23:0] m, l;
        for (int k = 0; k < 3; k++)
        begin
            v = scaled(r[k], g[k], o[k], s);
            m[8*k +: 8] = v[13:6];
            l[8*k +: 8] = fast ? 8'h00 : {v[5:0], 2'h0};
        end
        check("out_msb", m, out_msb);
        check("out_lsb", l, out_lsb);
    endtask

    task automatic pulse(input logic [4:0] b);
        @(negedge clk_sys);
        event_fire = b;
        @(negedge clk_sys);
        event_fire = 5'h00;
        repeat (2) @(negedge clk_sys);
    endtask

    initial
    begin
        repeat (8) @(negedge clk_sys);
        rst_b = 1'h1;
        for (i = 0; i < 400 && boot_done !== 1'h1; i++)
            @(negedge clk_sys);
        check("boot_done", 24'h1, boot_done);
        q[0] = ticks;
        repeat (60) @(negedge clk_sys);
        check("standby ticks", 24'h0, ticks - q[0]);
        check("analog_en", 24'h0, analog_en);
        active = 1'h1;
        repeat (60) @(negedge clk_sys);
        check("analog_en", 24'h1, analog_en);
        check("ticks running", 24'h1, ticks - q[0] >= 2);
        r = '{1000, -3000, 32767};
        for (i = 0; i < 5; i++)
        begin
            full_scale = (i == 4) ? 2'h0 : i[1:0];
            low_noise = (i == 4);
            feed(1);
            check("thresh_range", sh[i], thresh_range);
            check_axes(sh[i], 0);
        end
        low_noise = 1'h0;
        full_scale = 2'h0;
        fast_read = 1'h1;
        r = '{-700, 2200, -32768};
        feed(1);
        check_axes(0, 1);
        fast_read = 1'h0;
        for (i = 0; i < 4; i++)
        begin
            oversampling_ratio = i[1:0];
            r = '{100 * (i + 1), -50 * (i + 1), 7 * (i + 1)};
            feed(1 << i);
            check_axes(0, 0);
        end
        active = 1'h0;
        q = r;
        r = '{-1, -1, -1};
        feed(1);
        r = q;
        check_axes(0, 0);
        active = 1'h1;
        repeat (3) @(negedge clk_sys);
        check("out_msb", 24'h0, out_msb);
        check("out_lsb", 24'h0, out_lsb);
        pulse(5'h02);
        check("int_flags", 24'h02, int_flags);
        check("int2", 24'h1, int2);
        check("int1", 24'h0, int1);
        int_clear = 6'h02;
        @(negedge clk_sys);
        int_clear = 6'h00;
        repeat (2) @(negedge clk_sys);
        check("int2", 24'h0, int2);
        auto_sleep_en = 1'h1;
        for (i = 0; i < 300 && sleeping !== 1'h1; i++)
            @(negedge clk_sys);
        check("sleeping", 24'h1, sleeping);
        repeat (3) @(negedge clk_sys);
        check("int1", 24'h1, int1);
        pulse(5'h01);
        check("sleeping", 24'h0, sleeping);
        // Events inside every tick interval keep the timeout from expiring
        for (i = 0; i < 12; i++)
        begin
            pulse(5'h01);
            repeat (12) @(negedge clk_sys);
            check("sleeping", 24'h0, sleeping);
        end
        complete_run();
    end
endmodule // accel_mode_and_data_format_test

//--- tb/accel_mode_core_assertions.sv
/*
 * Concurrent checks on the ports of the accelerometer mode core.
 * Assumes one clk_sys domain with async active-low rst_b, and a
 * short BASE_PERIOD in simulation so that tick gaps stay small.
 */
`include "accel_mode_defs.vh"

module accel_mode_core_checker
#(
    parameter BASE_PERIOD = 20  // Cycles per fastest sample
)
(
    input wire        clk_sys,
    input wire        rst_b,
    input wire        active,
    input wire        low_noise,
    input wire [1:0]  full_scale,
    input wire [2:0]  wake_rate,
    input wire        auto_sleep_en,
    input wire [4:0]  event_fire,
    input wire [4:0]  wake_src_en,
    input wire [5:0]  int_enable,
    input wire [5:0]  int_route,
    input wire        nvm_ack,
    input wire        boot_done,
    input wire        analog_en,
    input wire        sample_tick,
    input wire [1:0]  thresh_range,
    input wire        sleeping,
    input wire [23:0] out_msb,
    input wire [23:0] out_lsb,
    input wire [5:0]  int_flags,
    input wire        int1
);
    timeunit 1ns;
    timeprecision 100ps;
    // Allowed wait for the next tick, twice the tick gap at the fastest rate
    localparam int TICK_LIM = 2 * BASE_PERIOD;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    property p_standby_still;
        !active && !analog_en |-> !sample_tick;
    endproperty
    a_standby_still: assert property (p_standby_still)
        else $error("sample tick while in standby");
    property p_analog_on;
        $rose(active) |=> analog_en;
    endproperty
    a_analog_on: assert property (p_analog_on)
        else $error("analog not enabled after activation");
    property p_tick_runs;
        sample_tick && active && !sleeping && wake_rate == 3'h0 |=>
            ##[0:TICK_LIM] (sample_tick || !active || sleeping ||
            wake_rate != 3'h0);
    endproperty
    a_tick_runs: assert property (p_tick_runs)
        else $error("sample tick stopped while active");
    property p_hold_standby;
        !active && $past(!active) |-> $stable(out_msb) && $stable(out_lsb);
    endproperty
    a_hold_standby: assert property (p_hold_standby)
        else $error("output bytes changed in standby");
    property p_clear_on_wake;
        $rose(active) |-> ##[0:2] (out_msb == 24'h000000);
    endproperty
    a_clear_on_wake: assert property (p_clear_on_wake)
        else $error("output bytes not cleared on activation");
    property p_lsb_pad;
        (out_lsb & 24'h030303) == 24'h000000;
    endproperty
    a_lsb_pad: assert property (p_lsb_pad)
        else $error("low byte padding bits not zero");
    property p_low_noise;
        low_noise |-> thresh_range == `RANGE_4G;
    endproperty
    a_low_noise: assert property (p_low_noise)
        else $error("low noise did not force the 4 g range");
    property p_range;
        !low_noise |-> thresh_range == (full_scale == 2'h0 ? `RANGE_2G :
            full_scale == 2'h1 ? `RANGE_4G : `RANGE_8G);
    endproperty
    a_range: assert property (p_range)
        else $error("threshold range differs from selected range");
    property p_boot;
        $rose(boot_done) |-> $past(nvm_ack);
    endproperty
    a_boot: assert property (p_boot)
        else $error("boot done without a trim answer");
    property p_sleep_flag;
        $rose(sleeping) && int_enable[5] |-> ##[1:2] int_flags[5];
    endproperty
    a_sleep_flag: assert property (p_sleep_flag)
        else $error("sleep entry not flagged");
    property p_wake;
        sleeping && active && |(event_fire & wake_src_en) |->
            ##[1:3] !sleeping;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake event did not end sleep");
    property p_no_auto;
        !auto_sleep_en [*3] |-> !sleeping;
    endproperty
    a_no_auto: assert property (p_no_auto)
        else $error("asleep with auto sleep disabled");
    property p_pin_one;
        $rose(int1) |-> $past(|(int_flags & int_route));
    endproperty
    a_pin_one: assert property (p_pin_one)
        else $error("pin one raised without a routed flag");
endmodule // accel_mode_core_checker

bind accel_mode_core accel_mode_core_checker
    #(.BASE_PERIOD(BASE_PERIOD)) accel_mode_core_checker_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .active(active),
    .low_noise(low_noise), .full_scale(full_scale),
    .wake_rate(wake_rate), .auto_sleep_en(auto_sleep_en),
    .event_fire(event_fire), .wake_src_en(wake_src_en),
    .int_enable(int_enable), .int_route(int_route), .nvm_ack(nvm_ack),
    .boot_done(boot_done), .analog_en(analog_en),
    .sample_tick(sample_tick), .thresh_range(thresh_range),
    .sleeping(sleeping), .out_msb(out_msb), .out_lsb(out_lsb),
    .int_flags(int_flags), .int1(int1));

//--- tb/nvm_model.sv
/*
 * Trim memory model: answers each read a fixed delay later.
 * Assumes one request outstanding at a time, on clk_sys.
 */
module nvm_model
#(
    parameter int DLY = 2  // Cycles from request to answer, less one
)
(
    input  wire        clk_sys,
    input  wire        rst_b,
    input  wire        nvm_rd,
    input  wire [2:0]  nvm_addr,
    output logic [7:0] nvm_data,
    output logic       nvm_ack
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] trim [0:5];  // Gain x,y,z then signed offset x,y,z
    int         wait_q;      // Cycles to answer, -1 when idle
    initial trim = '{8'h80, 8'h40, 8'h80, 8'h02, 8'hFE, 8'h00};

    // Idle data toggles so a stale word is never mistaken for an answer
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wait_q   <= -1;
            nvm_ack  <= 1'h0;
            nvm_data <= 8'h00;
        end
        else
        begin
            nvm_ack <= !nvm_rd && wait_q == 0;
            // Answer on the last wait cycle, otherwise keep toggling
            if (!nvm_rd && wait_q == 0)
                nvm_data <= trim[nvm_addr];
            else
                nvm_data <= ~nvm_data;
            if (nvm_rd)
                wait_q <= DLY;
            else if (wait_q >= 0)
                wait_q <= wait_q - 1;
        end
    end
endmodule // nvm_model
